/* hw/field_zero_defines.svh */
// Register offsets, field positions, reset values and timing counts of the field/zero block.
// Assumes a 100 MHz aclk and percentages in units of 0.01 % (10000 = 100.00 %).
`ifndef FIELD_ZERO_DEFINES_SVH
`define FIELD_ZERO_DEFINES_SVH
`define ADDR_CTRL 8'h00
`define ADDR_KEEP_WARM_LEVEL 8'h04
`define ADDR_DECAY_HOLD 8'h08
`define ADDR_ZERO_SPEED 8'h0C
`define ADDR_ZERO_CURRENT 8'h10
`define ADDR_MIN_FIELD 8'h14
`define ADDR_RATED_FIELD 8'h18
`define ADDR_SPILLOVER 8'h1C
`define ADDR_STATUS 8'h20
`define CTRL_KEEP_WARM 0
`define CTRL_IDLE_INHIBIT 1
`define CTRL_ZERO_REF_START 2
`define CTRL_WEAKENING 3
`define PCT_FULL 16'h2710
`define HYST_BAND 16'h0032
`define WEAKEN_STEP 16'h000A
`define RST_CTRL 4'h0
`define RST_KEEP_WARM_LEVEL 16'h0000
`define RST_DECAY_HOLD 16'h0000
`define RST_ZERO_SPEED 16'h0064
`define RST_ZERO_CURRENT 16'h0064
`define RST_MIN_FIELD 16'h0000
`define RST_RATED_FIELD 16'h2710
`define RST_SPILLOVER 16'h2710
`define CLK_PERIOD_NS 10
`define MS_PERIOD_NS 1000000
`define LOCKOUT_TIME_S 2
`define LOCKOUT_MS (`LOCKOUT_TIME_S * 1000)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hw/field_zero_pkg.sv */
// Types of the field/zero block: start-lockout states and the whole-module state record.
// Assumes the defines header is compiled alongside.
package field_zero_pkg;
  // Zero-reference start sequence
  typedef enum logic [1:0] {start_idle, start_wait, start_ok, start_locked} start_state_t;
  // Complete module state
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] ar_addr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [15:0] keep_warm_field_level;
    logic [15:0] field_decay_hold_time;
    logic [15:0] zero_speed_threshold;
    logic [15:0] zero_current_threshold;
    logic [15:0] min_field_level;
    logic [15:0] rated_field;
    logic [15:0] spillover_level;
    logic [31:0] ms_div;
    logic [15:0] hold_ms;
    logic hold_active;
    logic [15:0] start_ms;
    start_state_t start_st;
    logic running;
    logic ref_zero;
    logic pre_zero;
    logic fb_zero;
    logic cur_zero;
    logic [15:0] weaken;
    logic [15:0] field_demand;
    logic firing_enable;
    logic loops_enable;
    logic contactor_on;
  } state_t;
endpackage : field_zero_pkg

/* hw/field_zero_ctrl.sv */
// Field demand outside running and zero-speed interlocks, with an AXI4-Lite register slave.
// Assumes all command and measurement inputs are synchronous to aclk.
//
// Summary of operation
// R1: Standby off: field demand zero when stopped
// R2: Running means run and (start or jog)
// R3: Standby level 100.00% equals rated field
// R4: Quench delay keeps field after stopping
// R5: Field reference multiplies rated field current
// R6: Clamp field demand at minimum field
// R7: All zeros remove firing, loops stay active
// R8: One speed threshold, one current threshold
// R9: Zero current threshold never removes firing
// R10: Idle inhibit removes firing and quenches loops
// R11: Zero-reference start blocks current control
// R12: Two seconds unmet: lockout, contactor off
// R13: Symmetric thresholds, 0.5% hysteresis band
// R14: Standstill uses total, start uses pre-ramp
// R15: Speed null flag shares speed threshold
// R16: Reference null flag always computed
// R17: Spindle orientation needs idle inhibit off
// R18: Minimum field set with 5% margin
// R19: Derivative time 5 to 10% of integral
// R20: Feedback derivative/integral ratio below three
// R21: Weakening reduces field beyond spillover voltage
// R22: Comparisons every cycle on magnitudes
`timescale 1ns/1ps
`include "field_zero_defines.svh"

module field_zero_ctrl #(
  parameter int MS_CYCLES = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_cmd,
  input wire logic start_cmd,
  input wire logic jog_cmd,
  input wire logic signed [15:0] speed_ref_total,
  input wire logic signed [15:0] speed_ref_preramp,
  input wire logic signed [15:0] speed_feedback,
  input wire logic signed [15:0] current_demand,
  input wire logic [15:0] field_ref,
  input wire logic [15:0] arm_voltage,
  output logic [15:0] field_demand,
  output logic firing_enable,
  output logic loops_enable,
  output logic current_ctrl_enable,
  output logic contactor_on,
  output logic lockout_flag,
  output logic speed_null_flag,
  output logic ref_null_flag
);
  import field_zero_pkg::*;

  state_t s; // Registered state
  state_t n; // Next state
  logic next_ms_tick; // One-cycle millisecond enable
  logic [15:0] next_run_level; // Field demand while running
  logic [15:0] next_min_level; // Minimum field in amps units
  logic next_idle; // Idle inhibit condition
  logic next_still; // Standstill firing removal

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Magnitude, saturating so that -32768 does not wrap
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    if (v == 16'sh8000) begin
      return 16'h7FFF;
    end
    return v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  // Zero decision with a band around the threshold
  function automatic logic hyst(input logic prev, input logic [15:0] m, input logic [15:0] thr);
    logic [16:0] hi;
    logic [15:0] lo;
    hi = {1'b0, thr} + {1'b0, `HYST_BAND};
    lo = (thr > `HYST_BAND) ? 16'(thr - `HYST_BAND) : 16'h0000;
    return prev ? ({1'b0, m} <= hi) : (m < lo);
  endfunction : hyst

  // Percentage scaling; wide product avoids overflow before the divide
  function automatic logic [15:0] scale(input logic [15:0] a, input logic [15:0] pct);
    logic [31:0] p;
    p = ({16'h0000, a} * {16'h0000, pct}) / 32'(`PCT_FULL);
    return (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
  endfunction : scale

  // Byte-lane merge of the low two lanes
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    n = s;
    // Millisecond divider
    next_ms_tick = (s.ms_div == 32'(MS_CYCLES - 1));
    n.ms_div = next_ms_tick ? 32'h00000000 : s.ms_div + 32'h00000001;

    // Bus write: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      unique case ({s.aw_addr[7:2], 2'b00})
        `ADDR_CTRL: n.ctrl = s.w_strb[0] ? s.w_data[3:0] : s.ctrl;
        `ADDR_KEEP_WARM_LEVEL: begin
          n.keep_warm_field_level = merge(s.keep_warm_field_level, s.w_data, s.w_strb);
        end
        `ADDR_DECAY_HOLD: begin
          n.field_decay_hold_time = merge(s.field_decay_hold_time, s.w_data, s.w_strb);
        end
        `ADDR_ZERO_SPEED: begin
          n.zero_speed_threshold = merge(s.zero_speed_threshold, s.w_data, s.w_strb);
        end
        `ADDR_ZERO_CURRENT: begin
          n.zero_current_threshold = merge(s.zero_current_threshold, s.w_data, s.w_strb);
        end
        `ADDR_MIN_FIELD: n.min_field_level = merge(s.min_field_level, s.w_data, s.w_strb);
        `ADDR_RATED_FIELD: n.rated_field = merge(s.rated_field, s.w_data, s.w_strb);
        `ADDR_SPILLOVER: n.spillover_level = merge(s.spillover_level, s.w_data, s.w_strb);
        // Status is read-only; anything else is unmapped
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Bus read: one-cycle answer
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `ADDR_CTRL: n.rdata = {28'h0000000, s.ctrl};
        `ADDR_KEEP_WARM_LEVEL: n.rdata = {16'h0000, s.keep_warm_field_level};
        `ADDR_DECAY_HOLD: n.rdata = {16'h0000, s.field_decay_hold_time};
        `ADDR_ZERO_SPEED: n.rdata = {16'h0000, s.zero_speed_threshold};
        `ADDR_ZERO_CURRENT: n.rdata = {16'h0000, s.zero_current_threshold};
        `ADDR_MIN_FIELD: n.rdata = {16'h0000, s.min_field_level};
        `ADDR_RATED_FIELD: n.rdata = {16'h0000, s.rated_field};
        `ADDR_SPILLOVER: n.rdata = {16'h0000, s.spillover_level};
        `ADDR_STATUS: begin
          n.rdata = {s.field_demand, 5'h00, s.hold_active, s.cur_zero, s.pre_zero,
                     s.ref_zero, s.fb_zero, s.start_st == start_locked, s.contactor_on,
                     s.loops_enable, s.firing_enable, s.start_st == start_ok, s.running};
        end
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // Run decision
    n.running = run_cmd && (start_cmd || jog_cmd); // R2

    // Zero decisions on magnitudes, every cycle, one shared speed threshold
    n.ref_zero = hyst(s.ref_zero, mag(speed_ref_total), n.zero_speed_threshold); // R8 R13 R14 R16 R22
    n.pre_zero = hyst(s.pre_zero, mag(speed_ref_preramp), n.zero_speed_threshold); // R14 R22
    n.fb_zero = hyst(s.fb_zero, mag(speed_feedback), n.zero_speed_threshold); // R13 R15 R22
    // A zero threshold can never declare zero current
    n.cur_zero = (n.zero_current_threshold != 16'h0000) && // R9
                 hyst(s.cur_zero, mag(current_demand), n.zero_current_threshold); // R8 R13

    // Zero-reference start sequence, restarted whenever running stops
    if (!n.running) begin
      n.start_st = start_idle;
    end else begin
      unique case (s.start_st)
        start_idle: begin
          n.start_ms = 16'h0000;
          n.start_st = (n.ctrl[`CTRL_ZERO_REF_START] && !n.pre_zero) ? start_wait : start_ok; // R11
        end
        start_wait: begin
          if (n.pre_zero) begin
            n.start_st = start_ok; // R11
          end else if (next_ms_tick) begin
            if (s.start_ms == 16'(`LOCKOUT_MS - 1)) begin
              n.start_st = start_locked; // R12
            end else begin
              n.start_ms = s.start_ms + 16'h0001;
            end
          end
        end
        start_ok: n.start_st = start_ok;
        start_locked: n.start_st = start_locked;
      endcase
    end

    // Quench delay starts as running ends
    if (n.running) begin
      n.hold_active = 1'b0;
    end else if (s.running) begin
      n.hold_ms = 16'h0000;
      n.hold_active = (n.field_decay_hold_time != 16'h0000); // R4
    end else if (s.hold_active && next_ms_tick) begin
      if (s.hold_ms + 16'h0001 >= n.field_decay_hold_time) begin
        n.hold_active = 1'b0;
      end else begin
        n.hold_ms = s.hold_ms + 16'h0001;
      end
    end

    // Weakening factor: full until spillover, then trimmed back
    if (!n.ctrl[`CTRL_WEAKENING]) begin
      n.weaken = `PCT_FULL;
    end else if (next_ms_tick) begin
      if (arm_voltage > n.spillover_level) begin
        n.weaken = (s.weaken > `WEAKEN_STEP) ? 16'(s.weaken - `WEAKEN_STEP) : 16'h0000; // R21
      end else if (s.weaken < `PCT_FULL) begin
        n.weaken = (`PCT_FULL - s.weaken > `WEAKEN_STEP) ? 16'(s.weaken + `WEAKEN_STEP) :
                   `PCT_FULL; // R21
      end
    end

    // Field demand: external reference scales rated amps, then minimum clamp
    next_min_level = scale(n.rated_field, n.min_field_level);
    next_run_level = scale(scale(n.rated_field, field_ref), n.weaken); // R5 R21
    if (next_run_level < next_min_level) begin
      next_run_level = next_min_level; // R6
    end
    if (n.running || n.hold_active) begin
      n.field_demand = next_run_level; // R4
    end else if (n.ctrl[`CTRL_KEEP_WARM]) begin
      n.field_demand = scale(n.rated_field, n.keep_warm_field_level); // R3
    end else begin
      n.field_demand = 16'h0000; // R1
    end

    // Firing and loop gating
    next_idle = n.ctrl[`CTRL_IDLE_INHIBIT] && n.ref_zero && n.fb_zero; // R10
    next_still = n.ref_zero && n.cur_zero && n.fb_zero; // R7 R9
    n.firing_enable = n.running && (n.start_st == start_ok) && !next_still && !next_idle; // R7
    n.loops_enable = n.running && (n.start_st == start_ok) && !next_idle; // R10 R11
    n.contactor_on = n.running && (n.start_st != start_locked); // R12
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= `RST_CTRL;
      s.keep_warm_field_level <= `RST_KEEP_WARM_LEVEL;
      s.field_decay_hold_time <= `RST_DECAY_HOLD;
      s.zero_speed_threshold <= `RST_ZERO_SPEED;
      s.zero_current_threshold <= `RST_ZERO_CURRENT;
      s.min_field_level <= `RST_MIN_FIELD;
      s.rated_field <= `RST_RATED_FIELD;
      s.spillover_level <= `RST_SPILLOVER;
      s.weaken <= `PCT_FULL;
      s.start_st <= start_idle;
    end else begin
      s <= n;
    end
  end

  // Handshakes combinational; new address/data held off until the response leaves
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign field_demand = s.field_demand;
  assign firing_enable = s.firing_enable;
  assign loops_enable = s.loops_enable;
  assign current_ctrl_enable = s.start_st == start_ok;
  assign contactor_on = s.contactor_on;
  assign lockout_flag = s.start_st == start_locked;
  assign speed_null_flag = s.fb_zero; // R15
  assign ref_null_flag = s.ref_zero; // R16

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  not_running_a: assert property (!s.running |-> !s.firing_enable && !s.contactor_on) // R2
    else $error("firing or contactor while not running");
  standby_off_a: assert property (!s.running && !s.hold_active && !s.ctrl[`CTRL_KEEP_WARM] // R1
    |-> s.field_demand == 16'h0000)
    else $error("field demand not zero in stop");
  hold_start_a: assert property ($fell(s.running) && s.field_decay_hold_time != 16'h0000 // R4
    |-> s.hold_active)
    else $error("quench delay did not start");
  min_clamp_a: assert property (s.running // R6
    |-> s.field_demand >= scale(s.rated_field, s.min_field_level))
    else $error("field demand under minimum");
  idle_quench_a: assert property (s.ctrl[`CTRL_IDLE_INHIBIT] && s.ref_zero && s.fb_zero // R10
    |-> !s.firing_enable && !s.loops_enable)
    else $error("idle inhibit left firing or loops on");
  still_fire_a: assert property (s.ref_zero && s.cur_zero && s.fb_zero // R7
    |-> !s.firing_enable)
    else $error("firing not removed at standstill");
  cur_thr_zero_a: assert property (s.zero_current_threshold == 16'h0000 |-> !s.cur_zero) // R9
    else $error("zero current declared with zero threshold");
  // Same cycle: a reference reaching zero may legally enable the loops on the next edge
  ref_start_a: assert property (s.start_st == start_wait // R11
    |-> !s.loops_enable && !s.firing_enable)
    else $error("current control enabled before zero reference");
  lock_drop_a: assert property (s.start_st == start_locked |-> !s.contactor_on) // R12
    else $error("contactor held during lockout");
  // Threshold now registered is the one the decision used, even right after a write
  hyst_enter_a: assert property ($rose(s.fb_zero) // R13
    |-> $past(mag(speed_feedback)) < s.zero_speed_threshold)
    else $error("speed zero entered above threshold");

  lockout_c: cover property (s.start_st == start_wait ##1 s.start_st == start_locked);
  quench_c: cover property ($fell(s.running) ##1 s.hold_active [*3]);
  standstill_c: cover property (s.running && s.loops_enable && !s.firing_enable);
  weaken_c: cover property (s.ctrl[`CTRL_WEAKENING] && s.weaken < `PCT_FULL);
endmodule : field_zero_ctrl

/* testbench/motor_stage_model.sv */
// Stand-in for the power stage and motor: shaft speed and sensed armature voltage.
// Assumes the bench sets the target speed and voltage just after aclk edges.
`timescale 1ns/1ps

module motor_stage_model (
  input wire logic aclk,
  input wire logic contactor_on,
  input wire logic signed [15:0] spin_set,
  input wire logic [15:0] volt_set,
  output logic signed [15:0] speed_feedback = 16'sh0000,
  output logic [15:0] arm_voltage = 16'h0000
);
  ////////////////////////////////////////////////////////////////////////////////
  // Shaft and armature, one cycle behind the bench target
  always @(posedge aclk) begin
    speed_feedback <= spin_set;
    // Open contactor isolates the armature, so nothing is sensed
    arm_voltage <= contactor_on ? volt_set : 16'h0000;
  end
endmodule : motor_stage_model

/* testbench/tb_field_standby_zero_interlocks.sv */
// Self-checking bench of the field and zero-interlock block over AXI4-Lite.
// Assumes the motor stand-in closes the loop on speed feedback and armature voltage.
`timescale 1ns/1ps
`include "field_zero_defines.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module tb_field_standby_zero_interlocks;
  import field_zero_pkg::*;
  // Ordinary case: config and drive beside expected field, firing, loops
  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] lvl, minf;
    logic r, s, j;
    logic [15:0] sref, fb, cur, fref, fd;
    logic fire, loops;
  } row_t;
  localparam row_t rows [10] = '{
    '{4'h0, 16'h0000, 16'h0000, 0, 0, 0, 16'h0000, 16'h0000, 16'h0000, 16'h1388, 16'h0000, 0, 0},
    '{4'h1, 16'h09C4, 16'h0000, 0, 0, 0, 16'h0000, 16'h0000, 16'h0000, 16'h1388, 16'h09C4, 0, 0},
    '{4'h0, 16'h0000, 16'h0000, 1, 1, 0, 16'h0BB8, 16'h0BB8, 16'h03E8, 16'h1388, 16'h1388, 1, 1},
    '{4'h0, 16'h0000, 16'h0000, 1, 0, 1, 16'h0BB8, 16'h0BB8, 16'h03E8, 16'h1388, 16'h1388, 1, 1},
    '{4'h0, 16'h0000, 16'h0000, 0, 1, 1, 16'h0BB8, 16'h0BB8, 16'h03E8, 16'h1388, 16'h0000, 0, 0},
    '{4'h0, 16'h0000, 16'h0BB8, 1, 1, 0, 16'h0BB8, 16'h0BB8, 16'h03E8, 16'h03E8, 16'h0BB8, 1, 1},
    '{4'h0, 16'h0000, 16'h0000, 1, 1, 0, 16'h0000, 16'h0000, 16'h0000, 16'h1388, 16'h1388, 0, 1},
    '{4'h2, 16'h0000, 16'h0000, 1, 1, 0, 16'h0000, 16'h0000, 16'h0000, 16'h1388, 16'h1388, 0, 0},
    '{4'h2, 16'h0000, 16'h0000, 1, 1, 0, 16'hF448, 16'hF448, 16'h0000, 16'h1388, 16'h1388, 1, 1},
    '{4'h0, 16'h0000, 16'h0000, 1, 1, 0, 16'h0000, 16'h0000, 16'h03E8, 16'h1388, 16'h1388, 1, 1}
  };
  // Hysteresis walk: magnitudes around the 1 % default threshold
  localparam logic [15:0] hv [6] = '{16'h0BB8, 16'h0078, 16'h0028, 16'h0078, 16'h00A0, 16'hFFD8};
  localparam logic he [6] = '{0, 0, 1, 1, 0, 1};
  localparam logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  localparam logic [15:0] rv [8] = '{16'(`RST_CTRL), `RST_KEEP_WARM_LEVEL, `RST_DECAY_HOLD,
    `RST_ZERO_SPEED, `RST_ZERO_CURRENT, `RST_MIN_FIELD, `RST_RATED_FIELD, `RST_SPILLOVER};

  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic run_cmd = 1'b0, start_cmd = 1'b0, jog_cmd = 1'b0;
  logic signed [15:0] sref = 16'sh0, pre = 16'sh0, cur = 16'sh0, spin = 16'sh0, fbk;
  logic [15:0] fref = 16'h0, volt = 16'h0, arm, field_demand;
  logic firing_enable, loops_enable, current_ctrl_enable, contactor_on, lockout_flag;
  logic speed_null_flag, ref_null_flag;
  logic [31:0] got;
  int failures = 0, n_tests = 0;

  always #5 aclk = ~aclk;

  field_zero_ctrl #(.MS_CYCLES(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .run_cmd(run_cmd), .start_cmd(start_cmd), .jog_cmd(jog_cmd), .speed_ref_total(sref),
    .speed_ref_preramp(pre), .speed_feedback(fbk), .current_demand(cur), .field_ref(fref),
    .arm_voltage(arm), .field_demand(field_demand), .firing_enable(firing_enable),
    .loops_enable(loops_enable), .current_ctrl_enable(current_ctrl_enable),
    .contactor_on(contactor_on), .lockout_flag(lockout_flag),
    .speed_null_flag(speed_null_flag), .ref_null_flag(ref_null_flag));

  motor_stage_model motor_u (.aclk(aclk), .contactor_on(contactor_on), .spin_set(spin),
    .volt_set(volt), .speed_feedback(fbk), .arm_voltage(arm));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus helpers
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val

  // A wait that runs out is a mismatch and ends the run
  task automatic expire();
    failures++;
    give_verdict();
  endtask : expire

  // Settle: let a few edges pass, then look after the edge's updates
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : step

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, ad, wd, bd;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50 && !(ad && wd); k++) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge aclk);
      if (ha) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (hw) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    if (!(ad && wd)) expire();
    for (int k = 0; k < 50 && !bd; k++) begin
      @(negedge aclk);
      bd = bvalid;
      resp = bresp;
    end
    if (!bd) expire();
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  // Read: data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a);
    logic ha, rd_ok;
    ha = 1'b0;
    rd_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50 && !ha; k++) begin
      @(negedge aclk);
      ha = arready;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    if (!ha) expire();
    for (int k = 0; k < 50 && !rd_ok; k++) begin
      @(negedge aclk);
      rd_ok = rvalid;
      got = rdata;
      resp = rresp;
    end
    if (!rd_ok) expire();
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    step(2);
    `CHK(field_demand, 16'h0000);
    `CHK({awready, contactor_on, firing_enable}, 3'b100);
    @(posedge aclk);
    aresetn <= 1'b1;
    // Register reset values, then refused places
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      `CHK(got, rv[i]);
    end
    rd(8'h40);
    `CHK(resp, `RESP_SLVERR);
    `CHK(got, 32'h0);
    wr(`ADDR_STATUS, 32'h0);
    `CHK(resp, `RESP_SLVERR);
    // Ordinary cases from the table
    for (int i = 0; i < 10; i++) begin
      wr(`ADDR_CTRL, 32'(rows[i].ctrl));
      wr(`ADDR_KEEP_WARM_LEVEL, 32'(rows[i].lvl));
      wr(`ADDR_MIN_FIELD, 32'(rows[i].minf));
      @(posedge aclk);
      {run_cmd, start_cmd, jog_cmd} <= {rows[i].r, rows[i].s, rows[i].j};
      {sref, pre, spin} <= {rows[i].sref, rows[i].sref, rows[i].fb};
      {cur, fref} <= {rows[i].cur, rows[i].fref};
      step(6);
      `CHK(field_demand, rows[i].fd);
      `CHK({firing_enable, loops_enable}, {rows[i].fire, rows[i].loops});
    end
    // Hysteresis band on both flags, idle inhibit off
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      {sref, spin} <= {hv[i], hv[i]};
      step(6);
      `CHK({speed_null_flag, ref_null_flag}, {he[i], he[i]});
    end
    // Zero current threshold of zero keeps firing at standstill
    wr(`ADDR_ZERO_CURRENT, 32'h0);
    rd(`ADDR_ZERO_CURRENT);
    `CHK(got, 32'h0);
    cur <= 16'sh0;
    step(6);
    `CHK(firing_enable, 1'b1);
    wr(`ADDR_ZERO_CURRENT, 32'(`RST_ZERO_CURRENT));
    step(6);
    `CHK(firing_enable, 1'b0);
    // Quench delay of 3 ms holds the running demand after stop
    wr(`ADDR_DECAY_HOLD, 32'h3);
    run_cmd <= 1'b0;
    step(15);
    `CHK(field_demand, 16'h1388);
    step(30);
    `CHK(field_demand, 16'h0000);
    wr(`ADDR_DECAY_HOLD, 32'h0);
    // Start with reference not at zero: blocked, then locked out
    wr(`ADDR_CTRL, 32'h4);
    {sref, pre, spin} <= {16'sh0BB8, 16'sh0BB8, 16'sh0BB8};
    run_cmd <= 1'b1;
    step(6);
    `CHK({current_ctrl_enable, contactor_on, firing_enable}, 3'b010);
    step(19000);
    `CHK(lockout_flag, 1'b0);
    step(2500);
    `CHK({lockout_flag, contactor_on}, 2'b10);
    @(posedge aclk);
    run_cmd <= 1'b0;
    step(6);
    `CHK(lockout_flag, 1'b0);
    @(posedge aclk);
    run_cmd <= 1'b1;
    step(6);
    @(posedge aclk);
    pre <= 16'sh0;
    step(6);
    `CHK({current_ctrl_enable, contactor_on}, 2'b11);
    // Armature above spillover trims the field
    wr(`ADDR_SPILLOVER, 32'h1388);
    wr(`ADDR_CTRL, 32'h8);
    {fref, volt} <= {16'h2710, 16'h1F40};
    step(600);
    `CHK(field_demand < 16'h2710, 1'b1);
    give_verdict();
  end
endmodule : tb_field_standby_zero_interlocks
